// [hdl/spr_params.svh]
// Constants of the sensor serial register port: device addresses, command
// values, reset values, timing counts and the host controller's register map.
// Assumes a 250 MHz system clock and a mode 3 serial link.
// Functional notes
// - Select active low, pulled high when undriven
// - Sample input on rise, change output on fall
// - Master toggles select only while clock high
// - Control byte: read flag, seven address bits
// - Write is address byte plus data byte
// - Read streams bytes, address increments each byte
// - Conversions start only from control writes
// - Command codes for temperature and four pressures
// - Master waits maximum conversion time before reading; the testbench polls conv_busy instead
// - Results read from high, low, extension bytes
// - Calibration block read from its first address
// - Master keeps clocking eight cycles per byte
// - Temperature sixteen bits, pressure up to nineteen
// - Busy bit high until results are filled
// - Soft reset key repeats power-on reset
// - Clock idles high, second-edge sampling, 10 MHz
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH
`define SPR_A_CAL_FIRST 8'haa
`define SPR_A_CAL_LAST 8'hbf
`define SPR_CAL_BYTES 22
`define SPR_A_ID 8'hd0
`define SPR_A_SRST 8'he0
`define SPR_A_CTRL 8'hf4
`define SPR_A_MSB 8'hf6
`define SPR_A_LSB 8'hf7
`define SPR_A_XLSB 8'hf8
`define SPR_SRST_KEY 8'hb6
`define SPR_MSB_RST 8'h80
`define SPR_CMD_TEMP 8'h2e
`define SPR_CMD_P0 8'h34
`define SPR_CMD_P1 8'h74
`define SPR_CMD_P2 8'hb4
`define SPR_CMD_P3 8'hf4
`define SPR_CTRL_SCO 5
`define SPR_MC_TEMP 5'h0e
`define SPR_MC_PRES 5'h14
`define SPR_CLK_MHZ 64'd250
`define SPR_SCK_MAX_MHZ 64'd10
`define SPR_T_CONV0_NS 64'd4500000
`define SPR_T_CONV1_NS 64'd7500000
`define SPR_T_CONV2_NS 64'd13500000
`define SPR_T_CONV3_NS 64'd25500000
`define SPR_CYC(ns) (((ns) * `SPR_CLK_MHZ) / 64'd1000)
`define SPR_SCK_HALF ((64'd1000 * `SPR_CLK_MHZ + 64'd2000 * `SPR_SCK_MAX_MHZ - 64'd1) / (64'd2000 * `SPR_SCK_MAX_MHZ))
`define SPR_H_TX 8'h00
`define SPR_H_CMD 8'h04
`define SPR_H_STAT 8'h08
`define SPR_H_RX 8'h0c
`endif

// [hdl/spr_pkg.sv]
// Types of the sensor serial register port, both ends.
// Assumes spr_params.svh supplies the numeric constants.
`default_nettype none
package spr_pkg;
  typedef struct packed {
    logic [2:0] cnt; logic [6:0] sh; logic ph; logic rw; logic [7:0] addr;
  } spr_frame_t;
  typedef struct packed {logic [7:0] so; logic oe;} spr_out_t;
  typedef struct packed {
    logic rst_m; logic rst_s; logic ack; logic dn_m; logic dn_s; logic dn_seen;
    logic st_tgl; logic sr_tgl; logic [7:0] ctrl; logic [7:0] msb; logic [7:0] lsb; logic [7:0] xlsb;
  } spr_link_t;
  typedef struct packed {
    logic rst_req; logic ak_m; logic ak_s; logic st_m; logic st_s; logic st_seen;
    logic sr_m; logic sr_s; logic sr_seen; logic busy; logic temp; logic [31:0] cnt;
    logic dn_tgl; logic [7:0] r_msb; logic [7:0] r_lsb; logic [7:0] r_xlsb;
  } spr_core_t;
  typedef enum logic [2:0] {
    SPR_IDLE = 3'h0, SPR_LEAD = 3'h1, SPR_LOW = 3'h2, SPR_HIGH = 3'h3, SPR_TAIL = 3'h4, SPR_GAP = 3'h5
  } spr_hstate_t;
  typedef struct packed {
    spr_hstate_t st; logic [7:0] div; logic [2:0] bitn; logic [2:0] byten; logic [2:0] last;
    logic [7:0] sh; logic [31:0] rx; logic csb_n; logic csb_oe; logic sck; logic mosi;
    logic m1; logic m2; logic [7:0] dev_addr; logic [7:0] wdat; logic [1:0] len; logic rw;
    logic busy; logic done; logic [31:0] rdata;
  } spr_host_t;
endpackage : spr_pkg
`default_nettype wire

// [hdl/spr_if.sv]
// Four-wire serial link between host controller and sensor port.
// Resolves the select and data-out wires from the drivers' enables.
`default_nettype none
interface spr_if;
  logic csb_n_o;
  logic csb_oe;
  logic csb_n;
  logic sck;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Undriven select floats high through the pull-up
  assign csb_n = csb_oe ? csb_n_o : 1'b1;
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev (input csb_n, input sck, input mosi, output miso_o, output miso_oe);
  modport host (output csb_n_o, output csb_oe, output sck, output mosi, input miso);
endinterface : spr_if
`default_nettype wire

// [hdl/spr_dev.sv]
// Sensor end of the serial register port: frame decoder and register file
// on the link clock, conversion timer on the system clock.
// Assumes a mode 3 master and stable raw words while a conversion ends.
//
// Implementation choice: the plain strobed port.
`include "spr_params.svh"
`default_nettype none
module spr_dev #(
  parameter logic [7:0] CHIP_ID = 8'h5a, // Arbitrary value
  parameter logic [175:0] CAL_INIT = {11{16'hc35a}},
  parameter int unsigned CONV_T0 = 32'(`SPR_CYC(`SPR_T_CONV0_NS)),
  parameter int unsigned CONV_T1 = 32'(`SPR_CYC(`SPR_T_CONV1_NS)),
  parameter int unsigned CONV_T2 = 32'(`SPR_CYC(`SPR_T_CONV2_NS)),
  parameter int unsigned CONV_T3 = 32'(`SPR_CYC(`SPR_T_CONV3_NS))
) (
  // System side
  input wire logic clock,
  input wire logic nrst,
  // Serial link, clocked by its own clock
  spr_if.dev link,
  // Raw words from the converter
  input wire logic [15:0] raw_temperature_word,
  input wire logic [18:0] raw_pressure_word,
  // Conversion status
  output logic conv_busy
);

  spr_pkg::spr_frame_t fr_q, fr_d;
  spr_pkg::spr_out_t ng_q, ng_d;
  spr_pkg::spr_link_t lk_q, lk_d;
  spr_pkg::spr_core_t cr_q, cr_d;
  logic [7:0] cal_mem [0:`SPR_CAL_BYTES-1];
  logic [7:0] byte_in;
  logic byte_end;
  logic wr_en;
  logic [7:0] rd_byte;
  logic mc_ok;

  // Factory calibration, read only
  genvar gi;
  generate
    for (gi = 0; gi < `SPR_CAL_BYTES; gi++) begin : g_cal
      assign cal_mem[gi] = CAL_INIT[8*gi +: 8];
    end
  endgenerate

  // Frame decoder: bit count, control byte and address
  always_comb begin
    fr_d = fr_q;
    byte_in = {fr_q.sh, link.mosi};
    byte_end = (fr_q.cnt == 3'h7);
    wr_en = byte_end && fr_q.ph && !fr_q.rw;
    fr_d.cnt = fr_q.cnt + 3'h1;
    fr_d.sh = byte_in[6:0];
    if (byte_end) begin
      if (!fr_q.ph) begin
        fr_d.rw = byte_in[7];
        // All registers sit above 0x80, so the dropped bit is always one
        fr_d.addr = {1'b1, byte_in[6:0]};
        fr_d.ph = 1'b1;
      end else if (fr_q.rw) begin
        fr_d.addr = fr_q.addr + 8'h01;
      end else begin
        // Each pair stands alone; next byte is a new control byte
        fr_d.ph = 1'b0;
      end
    end
  end

  // Frame state dies with the select, so no sck edge is needed to clear it
  always_ff @(posedge link.sck or posedge link.csb_n) begin
    if (link.csb_n) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  // Read data for the current address
  always_comb begin
    rd_byte = 8'h00;
    if (fr_q.addr >= `SPR_A_CAL_FIRST && fr_q.addr <= `SPR_A_CAL_LAST) begin
      rd_byte = cal_mem[5'(fr_q.addr - `SPR_A_CAL_FIRST)];
    end else begin
      case (fr_q.addr)
        `SPR_A_ID: rd_byte = CHIP_ID;
        `SPR_A_CTRL: rd_byte = lk_q.ctrl;
        `SPR_A_MSB: rd_byte = lk_q.msb;
        `SPR_A_LSB: rd_byte = lk_q.lsb;
        `SPR_A_XLSB: rd_byte = lk_q.xlsb;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Output shifter on the falling edge; loads at each read byte boundary
  always_comb begin
    ng_d = ng_q;
    ng_d.oe = 1'b1;
    if (fr_q.ph && fr_q.rw && fr_q.cnt == 3'h0) begin
      ng_d.so = rd_byte;
    end else begin
      ng_d.so = {ng_q.so[6:0], 1'b0};
    end
  end

  always_ff @(negedge link.sck or posedge link.csb_n) begin
    if (link.csb_n) begin
      ng_q <= '0;
    end else begin
      ng_q <= ng_d;
    end
  end

  assign link.miso_o = ng_q.so[7];
  assign link.miso_oe = ng_q.oe;

  assign mc_ok = (byte_in[4:0] == `SPR_MC_TEMP) || (byte_in[4:0] == `SPR_MC_PRES);

  // Register file on the link clock. Its reset request comes from the core
  // because sck only runs inside frames; it lands in the first control byte.
  always_comb begin
    lk_d = lk_q;
    lk_d.rst_m = cr_q.rst_req;
    lk_d.rst_s = lk_q.rst_m;
    lk_d.ack = lk_q.rst_s;
    lk_d.dn_m = cr_q.dn_tgl;
    lk_d.dn_s = lk_q.dn_m;
    if (lk_q.dn_s != lk_q.dn_seen) begin
      lk_d.dn_seen = lk_q.dn_s;
      lk_d.msb = cr_q.r_msb;
      lk_d.lsb = cr_q.r_lsb;
      lk_d.xlsb = cr_q.r_xlsb;
      lk_d.ctrl[`SPR_CTRL_SCO] = 1'b0;
    end
    if (wr_en && fr_q.addr == `SPR_A_CTRL) begin
      lk_d.ctrl = {byte_in[7:6], lk_d.ctrl[`SPR_CTRL_SCO], byte_in[4:0]};
      // A command while one runs is stored but does not restart the timer
      if (byte_in[`SPR_CTRL_SCO] && !lk_d.ctrl[`SPR_CTRL_SCO] && mc_ok) begin
        lk_d.ctrl[`SPR_CTRL_SCO] = 1'b1;
        lk_d.st_tgl = ~lk_q.st_tgl;
      end
    end
    if (wr_en && fr_q.addr == `SPR_A_SRST && byte_in == `SPR_SRST_KEY) begin
      lk_d.ctrl = 8'h00;
      lk_d.msb = `SPR_MSB_RST;
      lk_d.lsb = 8'h00;
      lk_d.xlsb = 8'h00;
      lk_d.sr_tgl = ~lk_q.sr_tgl;
    end
    if (lk_q.rst_s) begin
      lk_d.dn_seen = 1'b0;
      lk_d.st_tgl = 1'b0;
      lk_d.sr_tgl = 1'b0;
      lk_d.ctrl = 8'h00;
      lk_d.msb = `SPR_MSB_RST;
      lk_d.lsb = 8'h00;
      lk_d.xlsb = 8'h00;
    end
  end

  always_ff @(posedge link.sck) begin
    lk_q <= lk_d;
  end

  // Conversion timer on the system clock
  always_comb begin
    cr_d = cr_q;
    cr_d.ak_m = lk_q.ack;
    cr_d.ak_s = cr_q.ak_m;
    cr_d.st_m = lk_q.st_tgl;
    cr_d.st_s = cr_q.st_m;
    cr_d.sr_m = lk_q.sr_tgl;
    cr_d.sr_s = cr_q.sr_m;
    if (cr_q.rst_req) begin
      // Link toggles are unknown until the link side has reset
      cr_d.st_seen = cr_q.st_s;
      cr_d.sr_seen = cr_q.sr_s;
      cr_d.busy = 1'b0;
      if (cr_q.ak_s) begin
        cr_d.rst_req = 1'b0;
      end
    end else if (cr_q.sr_s != cr_q.sr_seen) begin
      cr_d.sr_seen = cr_q.sr_s;
      cr_d.busy = 1'b0;
      cr_d.cnt = 32'h0;
    end else if (cr_q.st_s != cr_q.st_seen) begin
      // Control byte was written with the toggle and is stable by now
      cr_d.st_seen = cr_q.st_s;
      cr_d.busy = 1'b1;
      cr_d.temp = (lk_q.ctrl[4:0] == `SPR_MC_TEMP);
      if (cr_d.temp) begin
        cr_d.cnt = CONV_T0 - 32'h1;
      end else begin
        unique case (lk_q.ctrl[7:6])
          2'h0: cr_d.cnt = CONV_T0 - 32'h1;
          2'h1: cr_d.cnt = CONV_T1 - 32'h1;
          2'h2: cr_d.cnt = CONV_T2 - 32'h1;
          2'h3: cr_d.cnt = CONV_T3 - 32'h1;
        endcase
      end
    end else if (cr_q.busy) begin
      if (cr_q.cnt == 32'h0) begin
        cr_d.busy = 1'b0;
        cr_d.dn_tgl = ~cr_q.dn_tgl;
        if (cr_q.temp) begin
          cr_d.r_msb = raw_temperature_word[15:8];
          cr_d.r_lsb = raw_temperature_word[7:0];
          cr_d.r_xlsb = 8'h00;
        end else begin
          cr_d.r_msb = raw_pressure_word[18:11];
          cr_d.r_lsb = raw_pressure_word[10:3];
          cr_d.r_xlsb = {raw_pressure_word[2:0], 5'h00};
        end
      end else begin
        cr_d.cnt = cr_q.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cr_q <= '{rst_req: 1'b1, default: '0};
    end else begin
      cr_q <= cr_d;
    end
  end

  assign conv_busy = cr_q.busy;

endmodule : spr_dev
`default_nettype wire

// [hdl/spr_host.sv]
// Host end: drives select, serial clock and data from the system clock,
// taking orders through a small register port.
// Assumes a mode 3 device; data-out is synchronised before use.
`include "spr_params.svh"
`default_nettype none
module spr_host #(
  parameter logic [7:0] SCK_HALF = 8'(`SPR_SCK_HALF)
) (
  // System side
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Serial link
  spr_if.host link
);

  spr_pkg::spr_host_t h_q, h_d;
  logic [7:0] nxt;

  always_comb begin
    h_d = h_q;
    h_d.csb_oe = 1'b1;
    h_d.m1 = link.miso;
    h_d.m2 = h_q.m1;
    h_d.rdata = 32'h0;
    nxt = {h_q.sh[6:0], 1'b0};
    if (rd) begin
      case (addr)
        `SPR_H_TX: h_d.rdata = {14'h0, h_q.len, h_q.wdat, h_q.dev_addr};
        `SPR_H_STAT: h_d.rdata = {30'h0, h_q.done, h_q.busy};
        `SPR_H_RX: h_d.rdata = h_q.rx;
        default: h_d.rdata = 32'h0;
      endcase
    end
    if (wr && addr == `SPR_H_TX && !h_q.busy) begin
      h_d.dev_addr = wdata[7:0];
      h_d.wdat = wdata[15:8];
      h_d.len = wdata[17:16];
    end
    if (wr && addr == `SPR_H_STAT && wdata[1]) begin
      h_d.done = 1'b0;
    end
    if (wr && addr == `SPR_H_CMD && !h_q.busy && wdata[1:0] != 2'h0) begin
      h_d.rw = wdata[1];
      h_d.busy = 1'b1;
      h_d.st = spr_pkg::SPR_LEAD;
      h_d.csb_n = 1'b0;
      h_d.div = SCK_HALF - 8'h1;
      h_d.sh = {wdata[1], h_q.dev_addr[6:0]};
      h_d.bitn = 3'h0;
      h_d.byten = 3'h0;
      h_d.last = wdata[1] ? 3'(h_q.len) + 3'h1 : 3'h1;
      h_d.rx = 32'h0;
    end else if (h_q.div != 8'h0) begin
      h_d.div = h_q.div - 8'h1;
    end else begin
      unique case (h_q.st)
        spr_pkg::SPR_IDLE: h_d.st = spr_pkg::SPR_IDLE;
        spr_pkg::SPR_LEAD: begin
          h_d.sck = 1'b0;
          h_d.mosi = h_q.sh[7];
          h_d.st = spr_pkg::SPR_LOW;
          h_d.div = SCK_HALF - 8'h1;
        end
        spr_pkg::SPR_LOW: begin
          h_d.sck = 1'b1;
          h_d.st = spr_pkg::SPR_HIGH;
          h_d.div = SCK_HALF - 8'h1;
          if (h_q.rw && h_q.byten != 3'h0) begin
            h_d.rx = {h_q.rx[30:0], h_q.m2};
          end
        end
        spr_pkg::SPR_HIGH: begin
          h_d.div = SCK_HALF - 8'h1;
          h_d.bitn = h_q.bitn + 3'h1;
          if (h_q.bitn == 3'h7) begin
            h_d.byten = h_q.byten + 3'h1;
            // Reads keep clocking dummy zero bytes
            nxt = h_q.rw ? 8'h00 : h_q.wdat;
          end
          h_d.sh = nxt;
          if (h_q.bitn == 3'h7 && h_q.byten == h_q.last) begin
            h_d.st = spr_pkg::SPR_TAIL;
          end else begin
            h_d.sck = 1'b0;
            h_d.mosi = nxt[7];
            h_d.st = spr_pkg::SPR_LOW;
          end
        end
        spr_pkg::SPR_TAIL: begin
          h_d.csb_n = 1'b1;
          h_d.st = spr_pkg::SPR_GAP;
          h_d.div = SCK_HALF - 8'h1;
        end
        spr_pkg::SPR_GAP: begin
          h_d.st = spr_pkg::SPR_IDLE;
          h_d.busy = 1'b0;
          h_d.done = 1'b1;
        end
        default: h_d.st = spr_pkg::SPR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      h_q <= '{st: spr_pkg::SPR_IDLE, csb_n: 1'b1, sck: 1'b1, mosi: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign rdata = h_q.rdata;
  assign link.csb_n_o = h_q.csb_n;
  assign link.csb_oe = h_q.csb_oe;
  assign link.sck = h_q.sck;
  assign link.mosi = h_q.mosi;

endmodule : spr_host
`default_nettype wire

// [test/spr_link_assertions.sv]
// Checker of the serial link between the host and sensor ends.
// Assumes link wires and conv_busy sampled on the system clock.
`default_nettype none
module spr_link_assertions #(
  parameter int MAX_C = 3500
) (
  // System side
  input wire logic clock,
  input wire logic nrst,
  // Link wires
  input wire logic csb_oe,
  input wire logic csb_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  // Conversion status
  input wire logic conv_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock) begin
    if (!nrst || !conv_busy) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  AST_SEL_PULL: assert property (miso_oe |-> csb_oe && !csb_n) else $error("Data out driven while not selected");
  AST_OUT_RELEASED: assert property (csb_n |-> !miso_oe) else $error("Data out driven while idle");
  AST_SEL_EDGE_SCK: assert property ($changed(csb_n) |-> sck && $past(sck)) else $error("Select moved, clock low");
  AST_SCK_IDLE: assert property (csb_n |-> sck) else $error("Clock not idle high");
  AST_MOSI_FALL: assert property (!csb_n && !$past(csb_n) && $changed(mosi) |-> $fell(sck))
    else $error("Data in moved off falling edge");
  AST_MISO_FALL: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> $fell(sck))
    else $error("Data out moved off falling edge");
  AST_SCK_LOW_HALF: assert property ($fell(sck) |-> !sck [*8] ##1 !sck [*4]) else $error("Clock low too short");
  AST_SCK_HIGH_HALF: assert property ($rose(sck) && !csb_n |-> sck [*8] ##1 sck [*4])
    else $error("Clock high too short");
  AST_BUSY_CAUSE: assert property ($rose(conv_busy) |-> !$past(csb_n, 4)) else $error("Conversion without frame");
  AST_BUSY_SPAN: assert property ($rose(conv_busy) |-> conv_busy [*8] ##1 conv_busy [*8])
    else $error("Conversion ended at once");
  AST_BUSY_BOUND: assert property ($fell(conv_busy) |-> busy_cnt_q <= MAX_C + 8)
    else $error("Conversion too long");
endmodule : spr_link_assertions
`default_nettype wire

// [test/spr_sensor_register_port_tb.sv]
// Testbench: host and sensor ends joined over the serial link.
// Assumes the design files are compiled first; the host makes the link clock.
`include "spr_params.svh"
`default_nettype none
module spi_sensor_register_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] m; logic [31:0] v;} spr_note_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_p = 1'b0;
  logic [31:0] rdata;
  logic [15:0] tw = 16'h0;
  logic [18:0] pw = 19'h0;
  logic conv_busy;
  logic [31:0] rnd = 32'h00011e87;
  logic [7:0] sh = 8'h0;
  logic [7:0] cbyte = 8'h0;
  logic [5:0] bc = 6'h0;
  logic [7:0] cmd [5] = '{`SPR_CMD_TEMP, `SPR_CMD_P0, `SPR_CMD_P1, `SPR_CMD_P2, `SPR_CMD_P3};
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  spr_note_t cur;
  spr_note_t exp_q[$];
  `define SPR_CHK(a, b) begin \
    n_checks++; \
    if ((a) !== (b)) begin \
      bad_count++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (b)); \
    end \
  end
  spr_if lnk();
  spr_host u_spr_host (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(lnk));
  // Alternating calibration bytes show the address stepping
  spr_dev #(.CHIP_ID(8'h5a), .CAL_INIT({11{16'h3c96}}), .CONV_T0(2000), .CONV_T1(2500), .CONV_T2(3000),
    .CONV_T3(3500)) u_spr_dev (
    .clock(clock), .nrst(nrst), .link(lnk), .raw_temperature_word(tw), .raw_pressure_word(pw),
    .conv_busy(conv_busy));
  spr_link_assertions #(.MAX_C(3500)) u_spr_link_assertions (.clock(clock), .nrst(nrst), .csb_oe(lnk.csb_oe),
    .csb_n(lnk.csb_n), .sck(lnk.sck), .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe),
    .conv_busy(conv_busy));
  initial begin
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  // A zero mask marks a poll whose value is not judged
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, output logic [31:0] s);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back('{m, v});
    @(posedge clock);
    rd <= 1'b0;
    #1;
    s = rdata;
  endtask : rreg
  task automatic xfer(input logic [7:0] a, input logic [7:0] w, input int n, input logic rdf, input logic [31:0] v);
    logic [31:0] s;
    int k;
    wreg(8'h00, {14'h0, 2'(n - 1), w, a});
    wreg(8'h04, {30'h0, rdf, !rdf});
    s = 32'h0;
    for (k = 0; k < 3000 && s[1] !== 1'b1; k++) begin
      rreg(8'h08, 32'h0, 32'h0, s);
    end
    `SPR_CHK(s[1], 1'b1)
    wreg(8'h08, 32'h2);
    `SPR_CHK(cbyte, {rdf, a[6:0]})
    if (rdf) begin
      rreg(8'h0c, (n == 4) ? 32'hffffffff : ((32'h1 << (8 * n)) - 32'h1), v, s);
    end
  endtask : xfer
  // First byte of each frame, gathered from the wire MSB first
  always @(posedge lnk.sck or posedge lnk.csb_n) begin
    if (lnk.csb_n) begin
      bc <= 6'h0;
    end else begin
      sh <= {sh[6:0], lnk.mosi};
      bc <= bc + 6'h1;
      if (bc == 6'h7) begin
        cbyte <= {sh[6:0], lnk.mosi};
      end
    end
  end
  always @(posedge clock) begin
    rd_p <= rd;
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      conclude();
    end
  end
  always @(negedge clock) begin
    if (rd_p && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      if (cur.m != 32'h0) `SPR_CHK(rdata & cur.m, cur.v)
    end
  end
  initial begin
    int i;
    int k;
    logic [31:0] e;
    logic [31:0] s;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    // Identity value is the arbitrary one set at the instance
    xfer(8'hd0, 8'h00, 2, 1'b1, 32'h00005a00);
    xfer(8'haa, 8'h00, 4, 1'b1, 32'h963c963c);
    xfer(8'hbe, 8'h00, 3, 1'b1, 32'h00963c00);
    rreg(8'h10, 32'hffffffff, 32'h0, s);
    xfer(8'hf4, 8'h20, 1, 1'b0, 32'h0);
    `SPR_CHK(conv_busy, 1'b0)
    rreg(8'h00, 32'hffffffff, 32'h000020f4, s);
    // An empty command must not open a frame
    wreg(8'h04, 32'h0);
    rreg(8'h08, 32'h3, 32'h0, s);
    xfer(8'hf4, 8'h0e, 1, 1'b0, 32'h0);
    `SPR_CHK(conv_busy, 1'b0)
    for (i = 0; i < 5; i++) begin
      rnd = lf(rnd);
      tw <= rnd[15:0];
      pw <= rnd[18:0];
      xfer(8'hf4, cmd[i], 1, 1'b0, 32'h0);
      `SPR_CHK(conv_busy, 1'b1)
      xfer(8'hf4, 8'h00, 1, 1'b1, {24'h0, cmd[i]});
      for (k = 0; k < 8000 && conv_busy !== 1'b0; k++) begin
        @(posedge clock);
      end
      `SPR_CHK(conv_busy, 1'b0)
      e = (i == 0) ? {8'h0, tw, 8'h0} : {8'h0, pw, 5'h0};
      xfer(8'hf6, 8'h00, 3, 1'b1, e);
      xfer(8'hf4, 8'h00, 1, 1'b1, {24'h0, cmd[i] & 8'hdf});
    end
    // Reset key lands mid-conversion, so no result may follow
    xfer(8'hf4, 8'h2e, 1, 1'b0, 32'h0);
    `SPR_CHK(conv_busy, 1'b1)
    xfer(8'he0, 8'hb6, 1, 1'b0, 32'h0);
    `SPR_CHK(conv_busy, 1'b0)
    repeat (2100) @(posedge clock);
    `SPR_CHK(conv_busy, 1'b0)
    xfer(8'hf6, 8'h00, 3, 1'b1, 32'h00800000);
    xfer(8'hf4, 8'h00, 1, 1'b1, 32'h0);
    conclude();
  end
endmodule : spi_sensor_register_port_tb
`default_nettype wire
